// File: src/adcpt_control.v
// Purpose: digital control around a successive-approximation converter
// Assumes: analog core delivers an 11-bit raw word with a done pulse
// Notes: APB slave, pin-disable outputs, clock select/divide, trigger
`timescale 1ns/1ps
`include "adcpt_defines.vh"

module adcpt_control #(
  parameter PIN_GROUP = 8,
  parameter RAW_W = 11
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // clock sources
  input wire alternate_clock,
  input wire internal_async_clock,
  input wire low_power_mode,
  // hardware trigger
  input wire external_trigger_in,
  // analog core
  input wire core_done,
  input wire [RAW_W-1:0] core_raw,
  output reg core_start,
  output wire core_enable,
  output wire core_power_up,
  output wire core_low_power,
  output wire core_long_sample,
  output wire core_clk_en,
  output wire [4:0] core_channel,
  output wire async_clock_enable,
  // port logic for channels 8 to 23
  input wire [2*PIN_GROUP-1:0] port_out_in,
  input wire [2*PIN_GROUP-1:0] port_oe_in,
  input wire [2*PIN_GROUP-1:0] port_pullup_in,
  input wire [2*PIN_GROUP-1:0] pad_in,
  output wire [2*PIN_GROUP-1:0] pad_out,
  output wire [2*PIN_GROUP-1:0] pad_oe,
  output wire [2*PIN_GROUP-1:0] pad_pullup_en,
  output wire [2*PIN_GROUP-1:0] pad_ibuf_en,
  output wire [2*PIN_GROUP-1:0] port_read,
  // interrupt request
  output wire done_irq
);

  // --------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------
  reg [4:0] channel_select_ff;
  reg continuous_ff;
  reg done_irq_enable_ff;
  reg conversion_done_flag_ff;
  reg compare_gt_ff;
  reg compare_enable_ff;
  reg hw_trigger_enable_ff;
  reg [1:0] clock_source_select_ff;
  reg [1:0] mode_ff;
  reg long_sample_ff;
  reg [1:0] clock_divide_select_ff;
  reg low_power_ff;
  reg [1:0] result_high_ff;
  reg [7:0] result_low_ff;
  reg [1:0] compare_high_ff;
  reg [7:0] compare_low_ff;
  reg [PIN_GROUP-1:0] analog_pin_disable_mid_ff;
  reg [PIN_GROUP-1:0] analog_pin_disable_high_ff;
  reg trig_meta_ff;
  reg trig_sync_ff;
  reg trig_prev_ff;
  reg half_tgl_ff;
  reg [2:0] div_cnt_ff;
  reg hw_armed_ff;
  reg [31:0] rdata_ff;

  // one-hot converter states
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_DONE = 3'b100;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;

  wire wr = psel & penable & pwrite;
  wire rd = psel & ~penable & ~pwrite;
  wire wr_sc = wr & (paddr == `ADCPT_OFF_STATUS_CTRL);
  wire wr_cfg_any = wr & ((paddr == `ADCPT_OFF_MODE_CTRL) |
    (paddr == `ADCPT_OFF_CONFIG) | (paddr == `ADCPT_OFF_COMPARE_HIGH) |
    (paddr == `ADCPT_OFF_COMPARE_LOW));
  wire rd_low = psel & penable & ~pwrite &
    (paddr == `ADCPT_OFF_RESULT_LOW);

  // --------------------------------------------------------------------
  // enable and trigger
  // --------------------------------------------------------------------
  wire module_on = (channel_select_ff != `ADCPT_CH_ALL_ONES);
  wire hw_edge = trig_sync_ff & ~trig_prev_ff;
  wire sw_start = wr_sc & ~hw_trigger_enable_ff &
    (pwdata[`ADCPT_SC_CH_MSB:`ADCPT_SC_CH_LSB] != `ADCPT_CH_ALL_ONES);
  // busy or already-armed continuous run drops the edge, no queue
  wire hw_start = hw_trigger_enable_ff & hw_edge & module_on &
    (state_ff == ST_IDLE) & ~hw_armed_ff;
  wire conv_start = sw_start | hw_start;

  // --------------------------------------------------------------------
  // rounding and compare
  // --------------------------------------------------------------------
  function [9:0] round_raw;
    input [RAW_W-1:0] raw;
    input [1:0] mode;
    reg [RAW_W:0] sum;
    reg [RAW_W:0] sum8;
    begin
      sum = {1'b0, raw} + {{RAW_W{1'b0}}, 1'b1};
      // 9-bit word sits in the top bits, so round at its own lsb
      sum8 = {1'b0, raw} +
        ({{RAW_W{1'b0}}, 1'b1} << (RAW_W - `ADCPT_RAW8_W));
      if (mode == `ADCPT_MODE_10BIT) begin
        round_raw = (sum[RAW_W]) ? 10'h3FF : sum[RAW_W-1:1];
      end else begin
        round_raw = (sum8[RAW_W]) ? 10'h0FF :
          {2'b00, sum8[RAW_W-1:RAW_W-8]};
      end
    end
  endfunction

  wire [9:0] rounded = round_raw(core_raw, mode_ff);
  wire [9:0] cmp_val = (mode_ff == `ADCPT_MODE_10BIT) ?
    {compare_high_ff, compare_low_ff} : {2'b00, compare_low_ff};
  wire [10:0] cmp_diff = {1'b0, rounded} + {1'b0, ~cmp_val} + 11'h001;
  wire cmp_ge = cmp_diff[10];
  wire cmp_true = compare_gt_ff ? cmp_ge : ~cmp_ge;
  wire [9:0] store_val = compare_enable_ff ? cmp_diff[9:0] : rounded;
  wire transfer = (state_ff == ST_CONV) & core_done &
    (~compare_enable_ff | cmp_true);

  // --------------------------------------------------------------------
  // converter sequencing
  // --------------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (conv_start & module_on)
          nxt_state = ST_CONV;
      end
      ST_CONV: begin
        if (wr_cfg_any | ~module_on)
          nxt_state = ST_IDLE;
        else if (core_done)
          nxt_state = ST_DONE;
      end
      ST_DONE: begin
        if (continuous_ff & module_on)
          nxt_state = ST_CONV;
        else
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (sw_start)
      nxt_state = ST_CONV;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      core_start <= 1'b0;
      hw_armed_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // a status write that is a software start (hardware trigger off, channel not all ones) mid-conversion restarts the core as well
      core_start <= (nxt_state == ST_CONV) &
        ((state_ff != ST_CONV) | sw_start);
      if (~continuous_ff | ~hw_trigger_enable_ff | ~module_on)
        hw_armed_ff <= 1'b0;
      else if (hw_start)
        hw_armed_ff <= 1'b1;
    end
  end

  // power is up whenever the sequencer is not idle (converting or done)
  assign core_enable = module_on;
  assign core_power_up = (state_ff != ST_IDLE);
  assign core_low_power = low_power_ff;
  assign core_long_sample = long_sample_ff;
  assign core_channel = channel_select_ff;
  // async generator enabled when selected and the core is powered up, regardless of mode
  assign async_clock_enable = core_power_up &
    (clock_source_select_ff == `ADCPT_CLK_ASYNC);

  // --------------------------------------------------------------------
  // trigger synchroniser and clock divider
  // --------------------------------------------------------------------
  reg src_tick;
  always @* begin
    case (clock_source_select_ff)
      `ADCPT_CLK_BUS: src_tick = 1'b1;
      `ADCPT_CLK_BUS_HALF: src_tick = half_tgl_ff;
      `ADCPT_CLK_ALT: src_tick = alternate_clock;
      `ADCPT_CLK_ASYNC: src_tick = internal_async_clock | low_power_mode;
      default: src_tick = 1'b1;
    endcase
  end

  wire [2:0] div_mask = (3'h1 << clock_divide_select_ff) - 3'h1;
  assign core_clk_en = src_tick & ((div_cnt_ff & div_mask) == 3'h0);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_meta_ff <= 1'b0;
      trig_sync_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
      half_tgl_ff <= 1'b0;
      div_cnt_ff <= 3'h0;
    end else begin
      trig_meta_ff <= external_trigger_in;
      trig_sync_ff <= trig_meta_ff;
      trig_prev_ff <= trig_sync_ff;
      half_tgl_ff <= ~half_tgl_ff;
      if (src_tick)
        div_cnt_ff <= div_cnt_ff + 3'h1;
    end
  end

  // --------------------------------------------------------------------
  // register writes and result transfer
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_select_ff <= `ADCPT_CH_ALL_ONES;
      continuous_ff <= 1'b0;
      done_irq_enable_ff <= 1'b0;
      conversion_done_flag_ff <= 1'b0;
      compare_gt_ff <= 1'b0;
      compare_enable_ff <= 1'b0;
      hw_trigger_enable_ff <= 1'b0;
      clock_source_select_ff <= `ADCPT_CLK_BUS;
      mode_ff <= `ADCPT_MODE_8BIT;
      long_sample_ff <= 1'b0;
      clock_divide_select_ff <= 2'h0;
      low_power_ff <= 1'b0;
      result_high_ff <= 2'h0;
      result_low_ff <= `ADCPT_RST_BYTE;
      compare_high_ff <= 2'h0;
      compare_low_ff <= `ADCPT_RST_BYTE;
      analog_pin_disable_mid_ff <= {PIN_GROUP{1'b0}};
      analog_pin_disable_high_ff <= {PIN_GROUP{1'b0}};
    end else begin
      if (wr) begin
        case (paddr)
          `ADCPT_OFF_STATUS_CTRL: begin
            channel_select_ff <= pwdata[`ADCPT_SC_CH_MSB:`ADCPT_SC_CH_LSB];
            continuous_ff <= pwdata[`ADCPT_SC_CONT];
            done_irq_enable_ff <= pwdata[`ADCPT_SC_IEN];
          end
          `ADCPT_OFF_MODE_CTRL: begin
            compare_gt_ff <= pwdata[`ADCPT_MC_GT];
            compare_enable_ff <= pwdata[`ADCPT_MC_CMP_EN];
            hw_trigger_enable_ff <= pwdata[`ADCPT_MC_HWT_EN];
          end
          `ADCPT_OFF_CONFIG: begin
            clock_source_select_ff <=
              pwdata[`ADCPT_CF_CLK_MSB:`ADCPT_CF_CLK_LSB];
            mode_ff <= pwdata[`ADCPT_CF_MODE_MSB:`ADCPT_CF_MODE_LSB];
            long_sample_ff <= pwdata[`ADCPT_CF_LSMP];
            clock_divide_select_ff <=
              pwdata[`ADCPT_CF_DIV_MSB:`ADCPT_CF_DIV_LSB];
            low_power_ff <= pwdata[`ADCPT_CF_LPC];
          end
          `ADCPT_OFF_COMPARE_HIGH: compare_high_ff <= pwdata[1:0];
          `ADCPT_OFF_COMPARE_LOW: compare_low_ff <= pwdata[7:0];
          `ADCPT_OFF_PIN_MID:
            analog_pin_disable_mid_ff <= pwdata[PIN_GROUP-1:0];
          `ADCPT_OFF_PIN_HIGH:
            analog_pin_disable_high_ff <= pwdata[PIN_GROUP-1:0];
          default: ;
        endcase
      end
      // set wins over the clear from a status, mode, config or compare write or a low-byte read
      if (transfer) begin
        conversion_done_flag_ff <= 1'b1;
        result_low_ff <= store_val[7:0];
        if (mode_ff == `ADCPT_MODE_10BIT)
          result_high_ff <= store_val[9:8];
        else
          result_high_ff <= 2'h0;
      end else if (wr_sc | wr_cfg_any | rd_low) begin
        conversion_done_flag_ff <= 1'b0;
      end
    end
  end

  assign done_irq = conversion_done_flag_ff & done_irq_enable_ff;

  // --------------------------------------------------------------------
  // pin control
  // --------------------------------------------------------------------
  wire [2*PIN_GROUP-1:0] pin_off =
    {analog_pin_disable_high_ff, analog_pin_disable_mid_ff};
  assign pad_out = port_out_in & ~pin_off;
  assign pad_oe = port_oe_in & ~pin_off;
  assign pad_pullup_en = port_pullup_in & ~pin_off;
  assign pad_ibuf_en = ~pin_off;
  assign port_read = pad_in & ~pin_off;

  // --------------------------------------------------------------------
  // apb read path
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd) begin
      case (paddr)
        `ADCPT_OFF_STATUS_CTRL: rdata_ff <= {24'h00_0000,
          conversion_done_flag_ff, done_irq_enable_ff, continuous_ff,
          channel_select_ff};
        `ADCPT_OFF_MODE_CTRL: rdata_ff <= {24'h00_0000,
          (state_ff != ST_IDLE), hw_trigger_enable_ff,
          compare_enable_ff, compare_gt_ff, 4'h0};
        `ADCPT_OFF_CONFIG: rdata_ff <= {24'h00_0000, low_power_ff,
          clock_divide_select_ff, long_sample_ff, mode_ff,
          clock_source_select_ff};
        `ADCPT_OFF_RESULT_HIGH: rdata_ff <= {30'h0000_0000, result_high_ff};
        `ADCPT_OFF_RESULT_LOW: rdata_ff <= {24'h00_0000, result_low_ff};
        `ADCPT_OFF_COMPARE_HIGH:
          rdata_ff <= {30'h0000_0000, compare_high_ff};
        `ADCPT_OFF_COMPARE_LOW: rdata_ff <= {24'h00_0000, compare_low_ff};
        `ADCPT_OFF_PIN_MID:
          rdata_ff <= {24'h00_0000, analog_pin_disable_mid_ff};
        `ADCPT_OFF_PIN_HIGH:
          rdata_ff <= {24'h00_0000, analog_pin_disable_high_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = rdata_ff;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

endmodule // adcpt_control

// File: pkg/adcpt_defines.vh
// Purpose: constants for the converter control block
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes: definitions only
`ifndef ADCPT_DEFINES_VH
`define ADCPT_DEFINES_VH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADCPT_OFF_STATUS_CTRL 12'h000
`define ADCPT_OFF_MODE_CTRL 12'h004
`define ADCPT_OFF_CONFIG 12'h008
`define ADCPT_OFF_RESULT_HIGH 12'h00C
`define ADCPT_OFF_RESULT_LOW 12'h010
`define ADCPT_OFF_COMPARE_HIGH 12'h014
`define ADCPT_OFF_COMPARE_LOW 12'h018
`define ADCPT_OFF_PIN_MID 12'h01C
`define ADCPT_OFF_PIN_HIGH 12'h020
// ----------------------------------------------------------------------
// status/control fields (offset 0x000)
// ----------------------------------------------------------------------
`define ADCPT_SC_CH_LSB 0
`define ADCPT_SC_CH_MSB 4
`define ADCPT_SC_CONT 5
`define ADCPT_SC_IEN 6
`define ADCPT_SC_DONE 7
`define ADCPT_CH_ALL_ONES 5'h1F
// ----------------------------------------------------------------------
// mode control fields (offset 0x004)
// ----------------------------------------------------------------------
`define ADCPT_MC_GT 4
`define ADCPT_MC_CMP_EN 5
`define ADCPT_MC_HWT_EN 6
`define ADCPT_MC_ACTIVE 7
// ----------------------------------------------------------------------
// config fields (offset 0x008)
// ----------------------------------------------------------------------
`define ADCPT_CF_CLK_LSB 0
`define ADCPT_CF_CLK_MSB 1
`define ADCPT_CF_MODE_LSB 2
`define ADCPT_CF_MODE_MSB 3
`define ADCPT_CF_LSMP 4
`define ADCPT_CF_DIV_LSB 5
`define ADCPT_CF_DIV_MSB 6
`define ADCPT_CF_LPC 7
`define ADCPT_MODE_8BIT 2'h0
`define ADCPT_MODE_10BIT 2'h2
`define ADCPT_CLK_BUS 2'h0
`define ADCPT_CLK_BUS_HALF 2'h1
`define ADCPT_CLK_ALT 2'h2
`define ADCPT_CLK_ASYNC 2'h3
// ----------------------------------------------------------------------
// reset values and misc
// ----------------------------------------------------------------------
`define ADCPT_RST_SC 8'h1F
`define ADCPT_RST_BYTE 8'h00
`define ADCPT_RAW10_W 11
`define ADCPT_RAW8_W 9
`endif

// File: verification/adcpt_core_model.sv
// Purpose: behavioural analog core answering start pulses
// Assumes: one conversion at a time, fixed latency in bus cycles
// Notes: raw value is set by the bench; output is scrambled while idle
`timescale 1ns/1ps
module adcpt_core_model #(
  parameter LAT = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from the block
  input wire logic core_start,
  input wire logic core_enable,
  input wire logic [10:0] raw_val,
  // answer to the block
  output logic core_done,
  output logic [10:0] core_raw
);
  int cnt_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 0;
      core_done <= 1'b0;
      core_raw <= 11'h000;
    end else begin
      core_done <= 1'b0;
      // raw word is only valid with the done pulse
      core_raw <= ~core_raw;
      if (core_start && core_enable) begin
        cnt_ff <= LAT;
      end else if (cnt_ff == 1) begin
        cnt_ff <= 0;
        core_done <= 1'b1;
        core_raw <= raw_val;
      end else if (cnt_ff != 0) begin
        cnt_ff <= cnt_ff - 1;
      end
    end
  end
endmodule // adcpt_core_model

// File: verification/adcpt_control_chk.sv
// Purpose: concurrent checks on the converter control ports
// Assumes: single clock pclk, asynchronous active-low presetn
// Notes: attached by the bind at the foot of this file
`timescale 1ns/1ps
module adcpt_control_chk #(
  parameter PIN_GROUP = 8
) (
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // analog core
  input wire logic core_start,
  input wire logic core_enable,
  input wire logic [4:0] core_channel,
  // pins
  input wire logic [2*PIN_GROUP-1:0] port_oe_in,
  input wire logic [2*PIN_GROUP-1:0] pad_in,
  input wire logic [2*PIN_GROUP-1:0] pad_oe,
  input wire logic [2*PIN_GROUP-1:0] pad_pullup_en,
  input wire logic [2*PIN_GROUP-1:0] pad_ibuf_en,
  input wire logic [2*PIN_GROUP-1:0] port_read
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reset_state_a: assert property ($rose(presetn) |->
    &pad_ibuf_en && core_channel == 5'h1F) else $error("bad reset state");
  pin_tristate_a: assert property (
    (~pad_ibuf_en & (pad_oe | pad_pullup_en)) == '0)
    else $error("disabled pin still driven or pulled up");
  pin_read_a: assert property ((~pad_ibuf_en & port_read) == '0)
    else $error("disabled pin reads nonzero");
  pin_pass_a: assert property (
    (pad_ibuf_en & ((pad_oe ^ port_oe_in) | (port_read ^ pad_in))) == '0)
    else $error("enabled pin does not follow port logic");
  chan_off_a: assert property (core_channel == 5'h1F |-> !core_enable)
    else $error("core enabled with channel all ones");
  start_ok_a: assert property (core_start |-> core_enable)
    else $error("start while core disabled");
  start_pulse_a: assert property (core_start |=> !core_start)
    else $error("start pulse longer than one cycle");
  // read data must not move while software may still be taking it
  rd_hold_a: assert property (psel && penable && !pwrite |=> $stable(prdata))
    else $error("read data changed after access");
  unmapped_a: assert property (psel && penable && !pwrite &&
    paddr == 12'h0FC |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule // adcpt_control_chk

bind adcpt_control adcpt_control_chk #(.PIN_GROUP(PIN_GROUP)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .core_start(core_start), .core_enable(core_enable),
  .core_channel(core_channel), .port_oe_in(port_oe_in), .pad_in(pad_in),
  .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
  .pad_ibuf_en(pad_ibuf_en), .port_read(port_read)
);

// File: verification/adc_control_pin_trigger_test.sv
// Purpose: self-checking bench for the converter control block
// Assumes: zero-wait APB, core model answers after a fixed latency
// Notes: expectations come from field layout and round-half-up rule
`timescale 1ns/1ps
`include "adcpt_defines.vh"
module adc_control_pin_trigger_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, done_irq, core_start, core_enable, core_done;
  logic clk_en, pwr_up;
  logic [15:0] pad_out;
  int ticks = 0;
  logic alt_clk = 1'b0;
  logic external_trigger_in = 1'b0;
  logic [10:0] core_raw;
  logic [10:0] raw_val = 11'h000;
  logic [15:0] port_io = 16'h0000;
  logic [15:0] pad_oe, pad_pullup_en, pad_ibuf_en, port_read;
  logic [7:0] cfg;
  int err_count = 0;
  int checks = 0;
  int starts = 0;
  int s0;

  always #20 pclk = ~pclk;
  always @(posedge pclk) alt_clk <= ~alt_clk;
  always @(posedge pclk) if (core_start === 1'b1) starts <= starts + 1;
  always @(posedge pclk) if (clk_en === 1'b1) ticks <= ticks + 1;

  adcpt_control dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .alternate_clock(alt_clk),
    .internal_async_clock(~alt_clk), .low_power_mode(1'b0),
    .external_trigger_in(external_trigger_in), .core_done(core_done),
    .core_raw(core_raw), .core_start(core_start),
    .core_enable(core_enable), .core_power_up(pwr_up),
    .core_low_power(), .core_long_sample(), .core_clk_en(clk_en),
    .core_channel(), .async_clock_enable(), .port_out_in(port_io),
    .port_oe_in(port_io), .port_pullup_in(port_io), .pad_in(port_io),
    .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
    .pad_ibuf_en(pad_ibuf_en), .port_read(port_read), .done_irq(done_irq)
  );
  adcpt_core_model #(.LAT(6)) u_core (
    .pclk(pclk), .presetn(presetn), .core_start(core_start),
    .core_enable(core_enable), .raw_val(raw_val),
    .core_done(core_done), .core_raw(core_raw)
  );

  // ----
  // tasks
  // ----
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] a);
    checks++;
    if (a !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, a);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    if (pready !== 1'b1) begin
      chk("pready", 32'h0000_0001, 32'(pready));
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rdc(input string w, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(w, e, q);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (core_done !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (core_done !== 1'b1) begin
      chk("core_done", 32'h0000_0001, 32'(core_done));
      test_done();
    end
    repeat (2) @(posedge pclk);
  endtask

  // start on channel 3 with irq on, then check flag, irq and result
  task automatic conv(input logic [7:0] c, input logic [10:0] raw,
      input logic [7:0] hi, input logic [7:0] lo);
    raw_val <= raw;
    wr(`ADCPT_OFF_CONFIG, {24'h00_0000, c});
    wr(`ADCPT_OFF_STATUS_CTRL, 32'h0000_0043);
    wait_done();
    chk("done_irq", 32'h0000_0001, 32'(done_irq));
    rdc("status", `ADCPT_OFF_STATUS_CTRL, 32'h0000_00C3);
    if (c[3]) begin
      rdc("result_high", `ADCPT_OFF_RESULT_HIGH, {24'h00_0000, hi});
    end
    rdc("result_low", `ADCPT_OFF_RESULT_LOW, {24'h00_0000, lo});
    chk("irq_after_read", 32'h0000_0000, 32'(done_irq));
  endtask

  // count converter clock enables over 32 bus cycles
  task automatic clk_chk(input logic [7:0] c, input int e);
    int t0;
    wr(`ADCPT_OFF_CONFIG, {24'h00_0000, c});
    t0 = ticks;
    repeat (32) @(posedge pclk);
    chk("clk_en", 32'(e), 32'(ticks - t0));
  endtask

  // ----
  // sequence
  // ----
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("status", `ADCPT_OFF_STATUS_CTRL, 32'h0000_001F);
    chk("core_enable", 32'h0000_0000, 32'(core_enable));
    rdc("config", `ADCPT_OFF_CONFIG, 32'h0000_0000);
    rdc("pin_mid", `ADCPT_OFF_PIN_MID, 32'h0000_0000);
    rdc("pin_high", `ADCPT_OFF_PIN_HIGH, 32'h0000_0000);
    rdc("unmapped", 12'h0FC, 32'h0000_0000);
    $display("test reset done");
    port_io <= 16'hFFFF;
    wr(`ADCPT_OFF_PIN_MID, 32'h0000_00A5);
    wr(`ADCPT_OFF_PIN_HIGH, 32'h0000_003C);
    rdc("pin_mid", `ADCPT_OFF_PIN_MID, 32'h0000_00A5);
    rdc("pin_high", `ADCPT_OFF_PIN_HIGH, 32'h0000_003C);
    chk("pad_oe", 32'h0000_C35A, {16'h0000, pad_oe});
    chk("pullup", 32'h0000_C35A, {16'h0000, pad_pullup_en});
    chk("ibuf", 32'h0000_C35A, {16'h0000, pad_ibuf_en});
    chk("port_read", 32'h0000_C35A, {16'h0000, port_read});
    chk("pad_out", 32'h0000_C35A, {16'h0000, pad_out});
    $display("test pins done");
    for (int i = 0; i < 4; i++) begin
      cfg = {1'b0, i[1:0], 1'b0, (i[0] ? 2'b10 : 2'b00), i[1:0]};
      wr(`ADCPT_OFF_CONFIG, {24'h00_0000, cfg});
      rdc("config", `ADCPT_OFF_CONFIG, {24'h00_0000, cfg});
    end
    $display("test config done");
    conv(8'h08, 11'h2AB, 8'h01, 8'h56);
    conv(8'h08, 11'h7FF, 8'h03, 8'hFF);
    conv(8'h00, 11'h5A6, 8'h00, 8'hB5);
    $display("test conversion done");
    wr(`ADCPT_OFF_COMPARE_LOW, 32'h0000_0040);
    wr(`ADCPT_OFF_MODE_CTRL, 32'h0000_0030);
    conv(8'h00, 11'h280, 8'h00, 8'h10);
    raw_val <= 11'h100;
    wr(`ADCPT_OFF_STATUS_CTRL, 32'h0000_0043);
    wait_done();
    chk("cmp_false_irq", 32'h0000_0000, 32'(done_irq));
    rdc("cmp_false_low", `ADCPT_OFF_RESULT_LOW, 32'h0000_0010);
    $display("test compare done");
    clk_chk(8'h61, 2);
    clk_chk(8'h40, 8);
    clk_chk(8'h02, 16);
    clk_chk(8'h23, 8);
    $display("test clock done");
    wr(`ADCPT_OFF_MODE_CTRL, 32'h0000_0040);
    wr(`ADCPT_OFF_STATUS_CTRL, 32'h0000_0002);
    s0 = starts;
    repeat (4) @(posedge pclk);
    chk("sw_start", 32'(s0), 32'(starts));
    external_trigger_in <= 1'b1;
    repeat (3) @(posedge pclk);
    external_trigger_in <= 1'b0;
    repeat (2) @(posedge pclk);
    // second rise lands while the first conversion runs
    external_trigger_in <= 1'b1;
    wait_done();
    external_trigger_in <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("hw_starts", 32'(s0 + 1), 32'(starts));
    chk("power_up", 32'h0000_0000, 32'(pwr_up));
    $display("test trigger done");
    test_done();
  end
endmodule // adc_control_pin_trigger_test
